// *** pmtp_pkg.sv ***
package pmtp_pkg;

  // link widths and field layout
  localparam int PMTP_BYTE_W = 8;
  localparam int PMTP_NIB_W = 4;
  localparam logic [3:0] PMTP_NIB_ZERO = 4'h0;
  localparam logic [7:0] PMTP_BYTE_ZERO = 8'h00;

  // clock rates in kHz
  localparam int PMTP_SYS_KHZ = 10000;
  localparam int PMTP_MII10_KHZ = 2500;
  localparam int PMTP_MII100_KHZ = 25000;
  localparam int PMTP_GTX_KHZ = 125000;

  // mii transmit clock half periods in clk_sys cycles, rounded down, at least one
  localparam int PMTP_MII10_HALF_I = PMTP_SYS_KHZ / (2 * PMTP_MII10_KHZ);
  localparam int PMTP_MII100_HALF_I = PMTP_SYS_KHZ / (2 * PMTP_MII100_KHZ);
  localparam logic [7:0] PMTP_MII10_HALF = 8'((PMTP_MII10_HALF_I < 1) ? 1 : PMTP_MII10_HALF_I);
  localparam logic [7:0] PMTP_MII100_HALF = 8'((PMTP_MII100_HALF_I < 1) ? 1 : PMTP_MII100_HALF_I);

  // gigabit clock made by the mac: four clk_sys phases per period
  localparam logic [1:0] PMTP_PH_LOAD = 2'h0;
  localparam logic [1:0] PMTP_PH_RISE = 2'h1;
  localparam logic [1:0] PMTP_PH_SECOND = 2'h2;
  localparam logic [1:0] PMTP_PH_FALL = 2'h3;

  // cycles after reset release that the pin pulls stay on; the next cycle releases them
  localparam logic [7:0] PMTP_FUNC_CYC = 8'h10;

  // mac transmit buffer
  localparam logic [1:0] PMTP_FIFO_DEPTH = 2'h2;

  typedef enum logic [1:0] {
    PMTP_MODE_MII10,
    PMTP_MODE_MII100,
    PMTP_MODE_GMII,
    PMTP_MODE_RGMII
  } pmtp_mode_t;

  typedef enum logic [1:0] {
    PMTP_SYM_IDLE,
    PMTP_SYM_DATA,
    PMTP_SYM_INVALID,
    PMTP_SYM_HALT
  } pmtp_sym_t;

  typedef enum logic {
    PMTP_ERR_CLEAR,
    PMTP_ERR_HALTING
  } pmtp_err_state_t;

  typedef enum logic {
    PMTP_NIB_LOW,
    PMTP_NIB_HIGH
  } pmtp_nib_state_t;

endpackage

// *** pmtp_if.sv ***
`timescale 1ns/1ps
interface pmtp_if;
  logic mii_tx_clk;
  logic gigabit_transmit_clock;
  logic [pmtp_pkg::PMTP_BYTE_W-1:0] tx_data;
  logic tx_en_ctrl;
  logic transmit_error_input;

  modport phy (
    output mii_tx_clk,
    input gigabit_transmit_clock,
    input tx_data,
    input tx_en_ctrl,
    input transmit_error_input
  );

  modport mac (
    input mii_tx_clk,
    output gigabit_transmit_clock,
    output tx_data,
    output tx_en_ctrl,
    output transmit_error_input
  );
endinterface

// *** pmtp_phy_end.sv ***
`timescale 1ns/1ps
module pmtp_phy_end
  import pmtp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire pmtp_mode_t mode,
  pmtp_if.phy link,
  output logic pin_pull_en,
  output logic [PMTP_NIB_W-1:0] mii_sym_nibble,
  output pmtp_sym_t mii_sym_kind,
  output logic mii_sym_valid,
  output logic [PMTP_BYTE_W-1:0] gig_sym_data,
  output pmtp_sym_t gig_sym_kind,
  output logic gig_sym_valid
);

  logic mii_mode;
  logic [7:0] div_limit;
  logic [7:0] div_cnt_reg;
  logic tx_clk_reg;
  logic rise_now;
  logic [7:0] func_cnt_reg;
  pmtp_err_state_t err_state_reg;

  logic g_rst_s1_reg;
  logic g_rst_b_reg;
  pmtp_mode_t g_mode_s1_reg;
  pmtp_mode_t g_mode_reg;
  logic [PMTP_BYTE_W-1:0] g_data_reg;
  logic g_en_reg;
  logic g_er_reg;
  logic [PMTP_NIB_W-1:0] fall_nib_reg;
  logic fall_ctl_reg;

  assign mii_mode = (mode == PMTP_MODE_MII10) || (mode == PMTP_MODE_MII100);
  assign div_limit = (mode == PMTP_MODE_MII10) ? PMTP_MII10_HALF : PMTP_MII100_HALF;
  assign rise_now = mii_mode && (div_cnt_reg == 8'(div_limit - 8'h01)) && !tx_clk_reg;
  assign link.mii_tx_clk = tx_clk_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      func_cnt_reg <= 8'h00;
      pin_pull_en <= 1'b1;
    end else if (func_cnt_reg != PMTP_FUNC_CYC) begin
      func_cnt_reg <= 8'(func_cnt_reg + 8'h01);
    end else begin
      pin_pull_en <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_reg <= 8'h00;
      tx_clk_reg <= 1'b0;
    end else if (!mii_mode) begin
      div_cnt_reg <= 8'h00;
      tx_clk_reg <= 1'b0;
    end else if (div_cnt_reg == 8'(div_limit - 8'h01)) begin
      div_cnt_reg <= 8'h00;
      tx_clk_reg <= !tx_clk_reg;
    end else begin
      div_cnt_reg <= 8'(div_cnt_reg + 8'h01);
    end
  end

  // mii nibble sampling and error symbols
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mii_sym_valid <= 1'b0;
      mii_sym_nibble <= PMTP_NIB_ZERO;
      mii_sym_kind <= PMTP_SYM_IDLE;
      err_state_reg <= PMTP_ERR_CLEAR;
    end else begin
      mii_sym_valid <= rise_now;
      if (rise_now) begin
        mii_sym_nibble <= link.tx_data[PMTP_NIB_W-1:0];
        case (err_state_reg)
          PMTP_ERR_CLEAR: begin
            if (link.tx_en_ctrl && link.transmit_error_input) begin
              mii_sym_kind <= PMTP_SYM_INVALID;
              err_state_reg <= PMTP_ERR_HALTING;
            end else if (link.tx_en_ctrl) begin
              mii_sym_kind <= PMTP_SYM_DATA;
            end else begin
              mii_sym_kind <= PMTP_SYM_IDLE;
            end
          end
          PMTP_ERR_HALTING: begin
            if (link.transmit_error_input) begin
              mii_sym_kind <= PMTP_SYM_HALT;
            end else if (link.tx_en_ctrl) begin
              mii_sym_kind <= PMTP_SYM_DATA;
              err_state_reg <= PMTP_ERR_CLEAR;
            end else begin
              mii_sym_kind <= PMTP_SYM_IDLE;
              err_state_reg <= PMTP_ERR_CLEAR;
            end
          end
          default: begin
            mii_sym_kind <= PMTP_SYM_IDLE;
            err_state_reg <= PMTP_ERR_CLEAR;
          end
        endcase
      end
    end
  end

  // gigabit domain reset release
  always_ff @(posedge link.gigabit_transmit_clock or negedge rst_b) begin
    if (!rst_b) begin
      g_rst_s1_reg <= 1'b0;
      g_rst_b_reg <= 1'b0;
    end else begin
      g_rst_s1_reg <= 1'b1;
      g_rst_b_reg <= g_rst_s1_reg;
    end
  end

  // mode into gigabit domain
  always_ff @(posedge link.gigabit_transmit_clock or negedge g_rst_b_reg) begin
    if (!g_rst_b_reg) begin
      g_mode_s1_reg <= PMTP_MODE_MII10;
      g_mode_reg <= PMTP_MODE_MII10;
    end else begin
      g_mode_s1_reg <= mode;
      g_mode_reg <= g_mode_s1_reg;
    end
  end

  always_ff @(negedge link.gigabit_transmit_clock or negedge g_rst_b_reg) begin
    if (!g_rst_b_reg) begin
      fall_nib_reg <= PMTP_NIB_ZERO;
      fall_ctl_reg <= 1'b0;
    end else begin
      fall_nib_reg <= link.tx_data[PMTP_NIB_W-1:0];
      fall_ctl_reg <= link.tx_en_ctrl;
    end
  end

  always_ff @(posedge link.gigabit_transmit_clock or negedge g_rst_b_reg) begin
    if (!g_rst_b_reg) begin
      g_data_reg <= PMTP_BYTE_ZERO;
      g_en_reg <= 1'b0;
      g_er_reg <= 1'b0;
    end else begin
      g_data_reg[PMTP_NIB_W-1:0] <= link.tx_data[PMTP_NIB_W-1:0];
      if (g_mode_reg == PMTP_MODE_GMII) begin
        g_data_reg[PMTP_BYTE_W-1:PMTP_NIB_W] <= link.tx_data[PMTP_BYTE_W-1:PMTP_NIB_W];
      end else begin
        g_data_reg[PMTP_BYTE_W-1:PMTP_NIB_W] <= PMTP_NIB_ZERO;
      end
      g_en_reg <= link.tx_en_ctrl;
      g_er_reg <= link.transmit_error_input;
    end
  end

  // gigabit code-group decode
  always_ff @(posedge link.gigabit_transmit_clock or negedge g_rst_b_reg) begin
    if (!g_rst_b_reg) begin
      gig_sym_valid <= 1'b0;
      gig_sym_data <= PMTP_BYTE_ZERO;
      gig_sym_kind <= PMTP_SYM_IDLE;
    end else begin
      case (g_mode_reg)
        PMTP_MODE_GMII: begin
          gig_sym_valid <= 1'b1;
          gig_sym_data <= g_data_reg;
          if (g_er_reg) begin
            gig_sym_kind <= PMTP_SYM_INVALID;
          end else if (g_en_reg) begin
            gig_sym_kind <= PMTP_SYM_DATA;
          end else begin
            gig_sym_kind <= PMTP_SYM_IDLE;
          end
        end
        PMTP_MODE_RGMII: begin
          gig_sym_valid <= 1'b1;
          gig_sym_data <= {fall_nib_reg, g_data_reg[PMTP_NIB_W-1:0]};
          if (g_en_reg && (g_en_reg ^ fall_ctl_reg)) begin
            gig_sym_kind <= PMTP_SYM_INVALID;
          end else if (g_en_reg) begin
            gig_sym_kind <= PMTP_SYM_DATA;
          end else begin
            gig_sym_kind <= PMTP_SYM_IDLE;
          end
        end
        default: begin
          gig_sym_valid <= 1'b0;
          gig_sym_data <= PMTP_BYTE_ZERO;
          gig_sym_kind <= PMTP_SYM_IDLE;
        end
      endcase
    end
  end

endmodule

// *** pmtp_mac_end.sv ***
`timescale 1ns/1ps
module pmtp_mac_end
  import pmtp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire pmtp_mode_t mode,
  pmtp_if.mac link,
  input wire logic [PMTP_BYTE_W-1:0] in_data,
  input wire logic in_err,
  input wire logic in_valid,
  output logic in_ready
);

  logic mii_mode;
  logic rgmii_mode;
  logic gig_mode;
  logic [PMTP_BYTE_W:0] fifo_mem [PMTP_FIFO_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic [PMTP_BYTE_W:0] head;
  logic push;
  logic pop_gig;
  logic pop_mii;
  logic pop;
  logic [1:0] ph_reg;
  logic gtx_reg;
  logic [PMTP_BYTE_W-1:0] g_data_reg;
  logic g_en_reg;
  logic g_er_reg;
  logic [PMTP_NIB_W-1:0] sec_nib_reg;
  logic sec_ctl_reg;
  logic [PMTP_BYTE_W:0] hold_reg;
  logic req_tgl_reg;
  logic pend_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic ack_seen_reg;
  logic m_rst_s1_reg;
  logic m_rst_b_reg;
  logic req_s1_reg;
  logic req_s2_reg;
  logic req_seen_reg;
  logic ack_tgl_reg;
  pmtp_nib_state_t m_state_reg;
  logic [PMTP_NIB_W-1:0] m_data_reg;
  logic m_en_reg;
  logic m_er_reg;

  assign mii_mode = (mode == PMTP_MODE_MII10) || (mode == PMTP_MODE_MII100);
  assign rgmii_mode = (mode == PMTP_MODE_RGMII);
  assign gig_mode = !mii_mode;
  assign head = fifo_mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop_gig = gig_mode && (ph_reg == PMTP_PH_LOAD) && (count_reg != 2'h0);
  assign pop_mii = mii_mode && !pend_reg && (count_reg != 2'h0);
  assign pop = pop_gig || pop_mii;

  // drive pins from the domain of the active mode
  assign link.gigabit_transmit_clock = gtx_reg;
  assign link.tx_data = mii_mode ? {PMTP_NIB_ZERO, m_data_reg} : g_data_reg;
  assign link.tx_en_ctrl = mii_mode ? m_en_reg : g_en_reg;
  assign link.transmit_error_input = mii_mode ? m_er_reg : g_er_reg;

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = 2'(count_reg + 2'h1);
    end else if (pop && !push) begin
      count_next = 2'(count_reg - 2'h1);
    end
  end

  // two-entry transmit buffer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      in_ready <= 1'b0;
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_reg] <= {in_err, in_data};
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      count_reg <= count_next;
      in_ready <= (count_next != PMTP_FIFO_DEPTH);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ph_reg <= PMTP_PH_LOAD;
      gtx_reg <= 1'b0;
    end else begin
      ph_reg <= 2'(ph_reg + 2'h1);
      if (ph_reg == PMTP_PH_RISE) begin
        gtx_reg <= 1'b1;
      end else if (ph_reg == PMTP_PH_FALL) begin
        gtx_reg <= 1'b0;
      end
    end
  end

  // gmii and rgmii launch
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      g_data_reg <= PMTP_BYTE_ZERO;
      g_en_reg <= 1'b0;
      g_er_reg <= 1'b0;
      sec_nib_reg <= PMTP_NIB_ZERO;
      sec_ctl_reg <= 1'b0;
    end else if (gig_mode && (ph_reg == PMTP_PH_LOAD)) begin
      g_en_reg <= pop_gig;
      if (rgmii_mode) begin
        g_data_reg <= pop_gig ? {PMTP_NIB_ZERO, head[PMTP_NIB_W-1:0]} : PMTP_BYTE_ZERO;
        g_er_reg <= 1'b0;
        sec_nib_reg <= pop_gig ? head[PMTP_BYTE_W-1:PMTP_NIB_W] : PMTP_NIB_ZERO;
        sec_ctl_reg <= pop_gig && !head[PMTP_BYTE_W];
      end else begin
        g_data_reg <= pop_gig ? head[PMTP_BYTE_W-1:0] : PMTP_BYTE_ZERO;
        g_er_reg <= pop_gig && head[PMTP_BYTE_W];
      end
    end else if (rgmii_mode && (ph_reg == PMTP_PH_SECOND)) begin
      g_data_reg <= {PMTP_NIB_ZERO, sec_nib_reg};
      g_en_reg <= sec_ctl_reg;
    end
  end

  // mii handover toward transmit clock domain
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hold_reg <= '0;
      req_tgl_reg <= 1'b0;
      pend_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      if (pop_mii) begin
        hold_reg <= head;
        req_tgl_reg <= !req_tgl_reg;
        pend_reg <= 1'b1;
      end else if (ack_s2_reg != ack_seen_reg) begin
        ack_seen_reg <= ack_s2_reg;
        pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge link.mii_tx_clk or negedge rst_b) begin
    if (!rst_b) begin
      m_rst_s1_reg <= 1'b0;
      m_rst_b_reg <= 1'b0;
    end else begin
      m_rst_s1_reg <= 1'b1;
      m_rst_b_reg <= m_rst_s1_reg;
    end
  end

  always_ff @(posedge link.mii_tx_clk or negedge m_rst_b_reg) begin
    if (!m_rst_b_reg) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_seen_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      m_state_reg <= PMTP_NIB_LOW;
      m_data_reg <= PMTP_NIB_ZERO;
      m_en_reg <= 1'b0;
      m_er_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      case (m_state_reg)
        PMTP_NIB_LOW: begin
          if (req_s2_reg != req_seen_reg) begin
            req_seen_reg <= req_s2_reg;
            m_data_reg <= hold_reg[PMTP_NIB_W-1:0];
            m_en_reg <= 1'b1;
            m_er_reg <= hold_reg[PMTP_BYTE_W];
            m_state_reg <= PMTP_NIB_HIGH;
          end else begin
            m_data_reg <= PMTP_NIB_ZERO;
            m_en_reg <= 1'b0;
            m_er_reg <= 1'b0;
          end
        end
        PMTP_NIB_HIGH: begin
          m_data_reg <= hold_reg[PMTP_BYTE_W-1:PMTP_NIB_W];
          ack_tgl_reg <= !ack_tgl_reg;
          m_state_reg <= PMTP_NIB_LOW;
        end
        default: begin
          m_state_reg <= PMTP_NIB_LOW;
        end
      endcase
    end
  end

endmodule

// *** pmtp_checker_sva.sv ***
`timescale 1ns/1ps
module pmtp_checker
  import pmtp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire pmtp_mode_t mode,
  input wire logic mii_tx_clk,
  input wire logic gigabit_transmit_clock,
  input wire logic [PMTP_BYTE_W-1:0] tx_data,
  input wire logic tx_en_ctrl,
  input wire logic transmit_error_input
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  wire is_mii = (mode == PMTP_MODE_MII10) || (mode == PMTP_MODE_MII100);

  sequence s_mii10_cycle;
    mii_tx_clk [*2] ##1 !mii_tx_clk [*2] ##1 mii_tx_clk;
  endsequence
  sequence s_gtx_cycle;
    gigabit_transmit_clock [*2] ##1 !gigabit_transmit_clock [*2] ##1 gigabit_transmit_clock;
  endsequence

  a_mii_clk_off: assert property (!is_mii |-> !mii_tx_clk)
    else $error("mii clock active outside mii modes");
  a_mii10_period: assert property (mode == PMTP_MODE_MII10 && $rose(mii_tx_clk) |-> s_mii10_cycle)
    else $error("mii clock period wrong at low rate");
  a_mii100_period: assert property (mode == PMTP_MODE_MII100 && $rose(mii_tx_clk)
    |=> !mii_tx_clk ##1 mii_tx_clk)
    else $error("mii clock period wrong at high rate");
  a_gtx_free_run: assert property ($rose(gigabit_transmit_clock) |-> s_gtx_cycle)
    else $error("gigabit clock not continuous");
  a_gmii_data_hold: assert property (mode == PMTP_MODE_GMII && $rose(gigabit_transmit_clock)
    |=> $stable(tx_data) && $stable(tx_en_ctrl) && $stable(transmit_error_input))
    else $error("gmii pins move at the sampling edge");
  a_gmii_idle_err: assert property (mode == PMTP_MODE_GMII && !tx_en_ctrl |-> !transmit_error_input)
    else $error("error pin high while idle");
  a_rgmii_err_pin: assert property (mode == PMTP_MODE_RGMII |-> !transmit_error_input)
    else $error("error pin used in rgmii");
  a_mii_data_sync: assert property (is_mii && ($changed(tx_data[3:0]) || $changed(tx_en_ctrl))
    |-> $changed(mii_tx_clk))
    else $error("mii data not in step with its clock");
endmodule

// *** tb_phy_mac_transmit_port.sv ***
`timescale 1ns/1ps
module tb_phy_mac_transmit_port;
  import pmtp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  pmtp_mode_t mode = PMTP_MODE_MII10;
  logic [PMTP_BYTE_W-1:0] in_data = PMTP_BYTE_ZERO;
  logic in_err = 1'b0;
  logic in_valid = 1'b0;
  logic in_ready;
  logic pin_pull_en;
  logic [PMTP_NIB_W-1:0] mii_sym_nibble;
  pmtp_sym_t mii_sym_kind;
  logic mii_sym_valid;
  logic [PMTP_BYTE_W-1:0] gig_sym_data;
  pmtp_sym_t gig_sym_kind;
  logic gig_sym_valid;
  int failures = 0;
  int cmp_count = 0;
  logic stall_seen = 1'b0;
  logic [9:0] sym_q[$];
  logic [7:0] frame [4] = '{8'hA5, 8'h3C, 8'hF0, 8'h0F};
  logic [3:0] frame_err = 4'h2;
  pmtp_mode_t mode_tab [4] = '{PMTP_MODE_MII10, PMTP_MODE_MII100, PMTP_MODE_GMII, PMTP_MODE_RGMII};

  always #50 clk_sys = ~clk_sys;

  pmtp_if link ();
  pmtp_mac_end pmtp_mac_end_inst (.clk_sys(clk_sys), .rst_b(rst_b), .mode(mode), .link(link.mac),
    .in_data(in_data), .in_err(in_err), .in_valid(in_valid), .in_ready(in_ready));
  pmtp_phy_end pmtp_phy_end_inst (.clk_sys(clk_sys), .rst_b(rst_b), .mode(mode), .link(link.phy),
    .pin_pull_en(pin_pull_en), .mii_sym_nibble(mii_sym_nibble), .mii_sym_kind(mii_sym_kind),
    .mii_sym_valid(mii_sym_valid), .gig_sym_data(gig_sym_data), .gig_sym_kind(gig_sym_kind),
    .gig_sym_valid(gig_sym_valid));
  pmtp_checker pmtp_checker_inst (.clk_sys(clk_sys), .rst_b(rst_b), .mode(mode),
    .mii_tx_clk(link.mii_tx_clk), .gigabit_transmit_clock(link.gigabit_transmit_clock),
    .tx_data(link.tx_data), .tx_en_ctrl(link.tx_en_ctrl),
    .transmit_error_input(link.transmit_error_input));

  // collect non-idle symbols of both paths
  always @(negedge clk_sys) begin
    if (mii_sym_valid === 1'b1 && mii_sym_kind !== PMTP_SYM_IDLE) begin
      sym_q.push_back({mii_sym_kind, PMTP_NIB_ZERO, mii_sym_nibble});
    end
  end
  always @(negedge link.gigabit_transmit_clock) begin
    if (gig_sym_valid === 1'b1 && gig_sym_kind !== PMTP_SYM_IDLE) begin
      sym_q.push_back({gig_sym_kind, gig_sym_data});
    end
  end

  task results();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task miss(string msg);
    failures++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  task check_bit(logic got, logic exp, string msg);
    cmp_count++;
    if (got !== exp) miss(msg);
  endtask

  task check_sym(pmtp_sym_t got, pmtp_sym_t exp, string msg);
    cmp_count++;
    if (got !== exp) miss(msg);
  endtask

  task check_byte(logic [7:0] got, logic [7:0] exp, string msg);
    cmp_count++;
    if (got !== exp) miss(msg);
  endtask

  // offer one word and hold it until the buffer takes it
  task send(logic [7:0] b, logic e);
    int n;
    n = 0;
    in_data = b;
    in_err = e;
    in_valid = 1'b1;
    while (in_ready !== 1'b1 && n < 500) begin
      @(negedge clk_sys);
      n++;
      stall_seen = 1'b1;
    end
    if (in_ready !== 1'b1) begin
      miss("buffer never ready");
      results();
    end
    @(negedge clk_sys);
  endtask

  task run_mode(pmtp_mode_t m);
    int n;
    int cnt;
    int j;
    logic mii;
    logic [7:0] eb;
    pmtp_sym_t ek;
    mii = (m == PMTP_MODE_MII10) || (m == PMTP_MODE_MII100);
    cnt = mii ? 8 : 4;
    mode = m;
    rst_b = 1'b0;
    repeat (20) @(negedge clk_sys);
    check_bit(pin_pull_en, 1'b1, "pulls off in reset");
    rst_b = 1'b1;
    repeat (int'(PMTP_FUNC_CYC)) @(negedge clk_sys);
    check_bit(pin_pull_en, 1'b1, "pulls released early");
    @(negedge clk_sys);
    check_bit(pin_pull_en, 1'b0, "pulls still on");
    sym_q.delete();
    stall_seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      send(frame[i], frame_err[i]);
    end
    in_valid = 1'b0;
    n = 0;
    while (sym_q.size() < cnt && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    if (sym_q.size() < cnt) begin
      miss("symbols never arrived");
      results();
    end
    repeat (40) @(negedge clk_sys);
    check_bit(gig_sym_valid, !mii, "gigabit symbol valid level");
    check_bit(1'(sym_q.size() == cnt), 1'b1, "symbol count");
    if (m == PMTP_MODE_MII10) check_bit(stall_seen, 1'b1, "no back-pressure");
    for (int i = 0; i < cnt && i < sym_q.size(); i++) begin
      j = mii ? i / 2 : i;
      eb = !mii ? frame[j] : {PMTP_NIB_ZERO, (i % 2 == 1) ? frame[j][7:4] : frame[j][3:0]};
      ek = !frame_err[j] ? PMTP_SYM_DATA : (mii && i % 2 == 1) ? PMTP_SYM_HALT : PMTP_SYM_INVALID;
      check_sym(pmtp_sym_t'(sym_q[i][9:8]), ek, "symbol kind");
      if (!frame_err[j]) check_byte(sym_q[i][7:0], eb, "symbol data");
    end
  endtask

  initial begin
    for (int r = 0; r < 4; r++) begin
      run_mode(mode_tab[r]);
    end
    results();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    miss("run too long");
    results();
  end
endmodule
